// ### ilcr_defs.svh
`ifndef ILCR_DEFS_SVH
`define ILCR_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ILCR_OFS_VIN 8'h02
`define ILCR_OFS_IIN 8'h03
`define ILCR_OFS_PTL 8'h04

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ILCR_RST_VIN 8'h85
`define ILCR_RST_IIN 8'h39
`define ILCR_RST_PTL 8'h22
`define ILCR_VIN_DEF 5'h05

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ILCR_BIT_AUTORST 7
`define ILCR_BIT_BLEED 6
`define ILCR_BIT_AUDIO 5
`define ILCR_BIT_OPTSTART 7
`define ILCR_BIT_DETREQ 6
`define ILCR_BIT_OPTEN 5
`define ILCR_CODE_MSB 4
`define ILCR_PRE_MSB 7
`define ILCR_PRE_LSB 4
`define ILCR_TERM_MSB 3
`define ILCR_TERM_LSB 0

// ----------------------------------------
// Clamp codes
// ----------------------------------------
`define ILCR_VIN_MAX 5'h10
`define ILCR_IIN_MAX 5'h1C

`endif

// ### ilcr_pkg.sv
package ilcr_pkg;
   typedef logic [7:0] ilcr_byte_t;
   typedef logic [4:0] ilcr_code_t;
   typedef logic [3:0] ilcr_nibble_t;
endpackage : ilcr_pkg

// ### ilcr_regs.sv
// Overview of operation
// R01: Input voltage limit code, bits 4:0, default 4.4V.
// R02: Voltage codes above 10h apply as 5.5V.
// R03: Adapter plug-in reloads voltage code when enabled.
// R04: Auto-reload enable in bit 7, resets to 1.
// R05: Bit 5 turns off pulse-mode audio avoidance.
// R06: Reset values 85h and 39h.
// R07: Input current limit code, bits 4:0, default 3000mA.
// R08: Current codes above 1Ch apply as 3300mA.
// R09: Applied current is smaller of register and pin.
// R10: Optimizer start bit set-only, self-clears on start.
// R11: Start request ignored unless optimizer enabled.
// R12: Optimizer enable in bit 5, resets to 1.
// R13: Precharge bits 7:4, termination 3:0, reset 22h.
// R14: Pin limit used only while pin function enabled.
// R15: Reads return written code, clamp only applied.
`include "ilcr_defs.svh"

module ilcr_regs
   import ilcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic watchdogReset,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output ilcr_byte_t regRdData_r,
   input wire logic sourceDetectDone,
   input wire logic optimizerStarted,
   input wire logic limitPinFunctionEn,
   input wire logic [4:0] currentLimitPinCode,
   output logic vinLimitAutoresetEn_r,
   output logic batteryBleedLoadEn_r,
   output logic pulseModeAudioAvoidOff_r,
   output ilcr_code_t vinLimitApplied_r,
   output logic optimizerStartRequest_r,
   output logic sourceDetectRequest_r,
   output logic optimizerEnable_r,
   output ilcr_code_t iinLimitApplied_r,
   output ilcr_nibble_t prechargeCurrentCode_r,
   output ilcr_nibble_t terminationCurrentCode_r
);

   // ----------------------------------------
   // Decode and arithmetic
   // ----------------------------------------
   function automatic ilcr_code_t clampCode(input ilcr_code_t code, input ilcr_code_t maxCode);
      clampCode = (code > maxCode) ? maxCode : code;
   endfunction : clampCode

   // R06: reset words
   localparam ilcr_byte_t RstVin = `ILCR_RST_VIN;
   localparam ilcr_byte_t RstIin = `ILCR_RST_IIN;
   localparam ilcr_byte_t RstPtl = `ILCR_RST_PTL;

   ilcr_code_t inputVoltageLimitCode_r;
   ilcr_code_t inputCurrentLimitCode_r;
   logic wrVin;
   logic wrIin;
   logic wrPtl;
   logic optSet;
   ilcr_code_t iinClamped;

   assign wrVin = regWrEn && (regAddr == `ILCR_OFS_VIN);
   assign wrIin = regWrEn && (regAddr == `ILCR_OFS_IIN);
   assign wrPtl = regWrEn && (regAddr == `ILCR_OFS_PTL);
   // R11: enable gates start
   assign optSet = wrIin && regWrData[`ILCR_BIT_OPTSTART] && regWrData[`ILCR_BIT_OPTEN];
   assign iinClamped = clampCode(inputCurrentLimitCode_r, `ILCR_IIN_MAX);

   // ----------------------------------------
   // Input voltage limit register
   // ----------------------------------------
   // R04: auto-reload enable bit
   always_ff @(posedge clk) begin
      if (rst || watchdogReset) begin
         vinLimitAutoresetEn_r <= RstVin[`ILCR_BIT_AUTORST];
         batteryBleedLoadEn_r <= RstVin[`ILCR_BIT_BLEED];
      end else if (wrVin) begin
         vinLimitAutoresetEn_r <= regWrData[`ILCR_BIT_AUTORST];
         batteryBleedLoadEn_r <= regWrData[`ILCR_BIT_BLEED];
      end
   end

   // R05: audio avoidance control
   always_ff @(posedge clk) begin
      if (rst) begin
         pulseModeAudioAvoidOff_r <= RstVin[`ILCR_BIT_AUDIO];
      end else if (wrVin) begin
         pulseModeAudioAvoidOff_r <= regWrData[`ILCR_BIT_AUDIO];
      end
   end

   // R01: voltage code storage
   // The host write is taken over a plug-in reload in the same cycle, so software keeps the last word.
   always_ff @(posedge clk) begin
      if (rst) begin
         inputVoltageLimitCode_r <= RstVin[`ILCR_CODE_MSB:0];
      end else if (wrVin) begin
         inputVoltageLimitCode_r <= regWrData[`ILCR_CODE_MSB:0];
      // R03: plug-in reload
      end else if (sourceDetectDone && vinLimitAutoresetEn_r) begin
         inputVoltageLimitCode_r <= `ILCR_VIN_DEF;
      end
   end

   // R02: voltage clamp applied
   always_ff @(posedge clk) begin
      if (rst) begin
         vinLimitApplied_r <= RstVin[`ILCR_CODE_MSB:0];
      end else begin
         vinLimitApplied_r <= clampCode(inputVoltageLimitCode_r, `ILCR_VIN_MAX);
      end
   end

   // ----------------------------------------
   // Input current limit register
   // ----------------------------------------
   // R10: set-only start bit
   always_ff @(posedge clk) begin
      if (rst || watchdogReset) begin
         optimizerStartRequest_r <= RstIin[`ILCR_BIT_OPTSTART];
      end else if (optSet) begin
         optimizerStartRequest_r <= 1'b1;
      end else if (optimizerStarted) begin
         optimizerStartRequest_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || watchdogReset) begin
         sourceDetectRequest_r <= RstIin[`ILCR_BIT_DETREQ];
      end else if (wrIin) begin
         sourceDetectRequest_r <= regWrData[`ILCR_BIT_DETREQ];
      end
   end

   // R12: optimizer enable bit
   always_ff @(posedge clk) begin
      if (rst) begin
         optimizerEnable_r <= RstIin[`ILCR_BIT_OPTEN];
      end else if (wrIin) begin
         optimizerEnable_r <= regWrData[`ILCR_BIT_OPTEN];
      end
   end

   // R07: current code storage
   always_ff @(posedge clk) begin
      if (rst) begin
         inputCurrentLimitCode_r <= RstIin[`ILCR_CODE_MSB:0];
      end else if (wrIin) begin
         inputCurrentLimitCode_r <= regWrData[`ILCR_CODE_MSB:0];
      end
   end

   // R08: current clamp applied
   // R09: smaller of two
   // R14: pin function gate
   always_ff @(posedge clk) begin
      if (rst) begin
         iinLimitApplied_r <= RstIin[`ILCR_CODE_MSB:0];
      end else if (limitPinFunctionEn) begin
         iinLimitApplied_r <= clampCode(iinClamped, currentLimitPinCode);
      end else begin
         iinLimitApplied_r <= iinClamped;
      end
   end

   // ----------------------------------------
   // Precharge and termination register
   // ----------------------------------------
   // R13: nibble layout
   always_ff @(posedge clk) begin
      if (rst || watchdogReset) begin
         prechargeCurrentCode_r <= RstPtl[`ILCR_PRE_MSB:`ILCR_PRE_LSB];
         terminationCurrentCode_r <= RstPtl[`ILCR_TERM_MSB:`ILCR_TERM_LSB];
      end else if (wrPtl) begin
         prechargeCurrentCode_r <= regWrData[`ILCR_PRE_MSB:`ILCR_PRE_LSB];
         terminationCurrentCode_r <= regWrData[`ILCR_TERM_MSB:`ILCR_TERM_LSB];
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // R15: raw code readback
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData_r <= 8'h00;
      end else if (regRdEn) begin
         case (regAddr)
            `ILCR_OFS_VIN: begin
               regRdData_r <= {vinLimitAutoresetEn_r, batteryBleedLoadEn_r, pulseModeAudioAvoidOff_r,
                               inputVoltageLimitCode_r};
            end
            `ILCR_OFS_IIN: begin
               regRdData_r <= {optimizerStartRequest_r, sourceDetectRequest_r, optimizerEnable_r,
                               inputCurrentLimitCode_r};
            end
            `ILCR_OFS_PTL: begin
               regRdData_r <= {prechargeCurrentCode_r, terminationCurrentCode_r};
            end
            default: begin
               regRdData_r <= 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // R06: reset values
   a_reset_values: assert property ( // R06
         $past(rst) |-> {vinLimitAutoresetEn_r, batteryBleedLoadEn_r,
         pulseModeAudioAvoidOff_r, inputVoltageLimitCode_r} == `ILCR_RST_VIN
         && {optimizerStartRequest_r, sourceDetectRequest_r, optimizerEnable_r, inputCurrentLimitCode_r}
         == `ILCR_RST_IIN && {prechargeCurrentCode_r, terminationCurrentCode_r} == `ILCR_RST_PTL)
      else $error("Register reset value wrong.");

   // R02: voltage clamp
   a_vin_clamp_max: assert property ( // R02
         ##1 vinLimitApplied_r == (($past(inputVoltageLimitCode_r) > 5'h10)
         ? 5'h10 : $past(inputVoltageLimitCode_r)))
      else $error("Applied voltage limit not clamped to code 10h.");

   // R03: plug-in reload
   a_vin_plug_reload: assert property ( // R03
         sourceDetectDone && vinLimitAutoresetEn_r && !wrVin && !watchdogReset
         |=> inputVoltageLimitCode_r == 5'h05 ##1 vinLimitApplied_r == 5'h05)
      else $error("Voltage code not reloaded on plug-in.");

   // R04: reload disabled
   a_vin_no_reload: assert property ( // R04
         sourceDetectDone && !vinLimitAutoresetEn_r && !wrVin
         |=> $stable(inputVoltageLimitCode_r))
      else $error("Voltage code reloaded while auto-reload off.");

   // R08: current clamp
   a_iin_clamp_max: assert property ( // R08
         !limitPinFunctionEn ##1 1'b1 |-> iinLimitApplied_r
         == (($past(inputCurrentLimitCode_r) > 5'h1C) ? 5'h1C : $past(inputCurrentLimitCode_r)))
      else $error("Applied current limit not clamped to code 1Ch.");

   // R09: pin minimum
   a_iin_pin_min: assert property ( // R09
         limitPinFunctionEn |=> iinLimitApplied_r <= $past(currentLimitPinCode)
         && iinLimitApplied_r <= 5'h1C)
      else $error("Applied current exceeds pin limit.");

   // R11: ignored start
   a_opt_ignored: assert property ( // R11
         wrIin && !regWrData[5] && !optimizerStartRequest_r && !watchdogReset
         |=> !optimizerStartRequest_r)
      else $error("Start request taken while optimizer disabled.");

   sequence s_opt_set;
      optSet && !watchdogReset;
   endsequence
   sequence s_opt_ack;
      optimizerStarted && !optSet && !watchdogReset;
   endsequence

   // R10: set then clear
   a_opt_set_clear: assert property ( // R10
         s_opt_set ##1 s_opt_ack |-> optimizerStartRequest_r ##1
         !optimizerStartRequest_r)
      else $error("Start bit did not set then self-clear.");

   // R10: set beats clear
   a_opt_set_wins: assert property (s_opt_set and optimizerStarted |=> optimizerStartRequest_r) // R10
      else $error("Start request lost against clear.");

   // R15: readback of written code
   a_vin_readback: assert property ( // R15
         wrVin && !watchdogReset ##1 regRdEn && regAddr == 8'h02 && !regWrEn
         |=> regRdData_r[4:0] == $past(regWrData[4:0], 2))
      else $error("Voltage code readback differs from write.");

   // R04: watchdog field reset
   a_wd_field_reset: assert property ( // R04
         watchdogReset |=> vinLimitAutoresetEn_r == RstVin[`ILCR_BIT_AUTORST]
         && batteryBleedLoadEn_r == RstVin[`ILCR_BIT_BLEED]
         && optimizerStartRequest_r == RstIin[`ILCR_BIT_OPTSTART]
         && sourceDetectRequest_r == RstIin[`ILCR_BIT_DETREQ]
         && {prechargeCurrentCode_r, terminationCurrentCode_r} == RstPtl)
      else $error("Watchdog did not restore its fields.");

   // R12: watchdog keeps settings
   a_wd_keeps_codes: assert property ( // R12
         watchdogReset && !wrVin && !wrIin && !sourceDetectDone
         |=> $stable(inputVoltageLimitCode_r) && $stable(inputCurrentLimitCode_r)
         && $stable(optimizerEnable_r) && $stable(pulseModeAudioAvoidOff_r))
      else $error("Watchdog changed a field it must keep.");

   // R10: request stands
   a_opt_holds: assert property ( // R10
         optimizerStartRequest_r && !optimizerStarted && !watchdogReset
         |=> optimizerStartRequest_r)
      else $error("Start bit dropped before optimizer start.");

   // R07: current field write
   a_iin_write: assert property ( // R07
         wrIin |=> inputCurrentLimitCode_r == $past(regWrData[`ILCR_CODE_MSB:0])
         && optimizerEnable_r == $past(regWrData[`ILCR_BIT_OPTEN]))
      else $error("Current register write not stored.");

   // R05: voltage control bits
   a_vin_ctrl_write: assert property ( // R05
         wrVin && !watchdogReset |=> {vinLimitAutoresetEn_r, batteryBleedLoadEn_r,
         pulseModeAudioAvoidOff_r} == $past(regWrData[7:5]))
      else $error("Voltage register control bits not stored.");

   // R13: precharge field write
   a_ptl_write: assert property ( // R13
         wrPtl && !watchdogReset |=> {prechargeCurrentCode_r, terminationCurrentCode_r}
         == $past(regWrData))
      else $error("Precharge register write not stored.");

endmodule : ilcr_regs

// ### ilcr_host_model.sv
module ilcr_host_model
   import ilcr_pkg::*;
(
   input wire logic clk,
   output ilcr_byte_t regAddr,
   output logic regWrEn,
   output ilcr_byte_t regWrData,
   output logic regRdEn,
   input wire ilcr_byte_t regRdData_r
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regWrData = 8'h00;
      regRdEn = 1'b0;
   end

   // single byte writes.
   // Released lines show inverted values so that stale data is never mistaken for a valid byte.
   task automatic wr(input ilcr_byte_t a, input ilcr_byte_t d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask : wr

   task automatic rd(input ilcr_byte_t a, output ilcr_byte_t d);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdData_r;
   endtask : rd
endmodule : ilcr_host_model

// ### ilcr_regs_tb_top.sv
`include "ilcr_defs.svh"

module ilcr_regs_tb_top;
   import ilcr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wdReset = 1'b0;
   logic detDone = 1'b0;
   logic optStarted = 1'b0;
   logic pinEn = 1'b0;
   ilcr_code_t pinCode = 5'h00;
   ilcr_byte_t regAddr, regWrData, regRdData_r, rdv, d;
   logic regWrEn, regRdEn, autoEn, bleedEn, audioOff, optReq, detReq, optEn;
   ilcr_code_t vinApp, iinApp;
   ilcr_nibble_t preCode, termCode;
   ilcr_code_t corners [4] = '{5'h10, 5'h11, 5'h1C, 5'h1D};
   int nErrors = 0;
   int checked = 0;
   integer seed = 32'h14e6;

   always #2 clk = ~clk;

   ilcr_host_model ilcr_host_model_inst (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r));

   ilcr_regs ilcr_regs_inst (.clk(clk), .rst(rst), .watchdogReset(wdReset), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
      .sourceDetectDone(detDone), .optimizerStarted(optStarted), .limitPinFunctionEn(pinEn),
      .currentLimitPinCode(pinCode), .vinLimitAutoresetEn_r(autoEn), .batteryBleedLoadEn_r(bleedEn),
      .pulseModeAudioAvoidOff_r(audioOff), .vinLimitApplied_r(vinApp), .optimizerStartRequest_r(optReq),
      .sourceDetectRequest_r(detReq), .optimizerEnable_r(optEn), .iinLimitApplied_r(iinApp),
      .prechargeCurrentCode_r(preCode), .terminationCurrentCode_r(termCode));

   // ----------------------------------------
   // Expectations and checks
   // ----------------------------------------
   function automatic ilcr_code_t vinExp(input ilcr_code_t c);
      return (c > 5'h10) ? 5'h10 : c;
   endfunction : vinExp

   function automatic ilcr_code_t iinExp(input ilcr_code_t c, input logic en, input ilcr_code_t p);
      ilcr_code_t m;
      m = (c > 5'h1C) ? 5'h1C : c;
      return (en && p < m) ? p : m;
   endfunction : iinExp

   task automatic chk(input ilcr_byte_t got, input ilcr_byte_t exp);
      checked++;
      if (got !== exp) begin
         nErrors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rdChk(input ilcr_byte_t a, input ilcr_byte_t e);
      ilcr_host_model_inst.rd(a, rdv);
      chk(rdv, e);
   endtask : rdChk

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse

   task automatic closeOut();
      $display("counts checked=%0d errors=%0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : closeOut

   // A hung sequence is cut short here and counted as a mismatch.
   initial begin
      repeat (20000) @(negedge clk);
      nErrors++;
      closeOut();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      rdChk(`ILCR_OFS_VIN, 8'h85);
      rdChk(`ILCR_OFS_IIN, 8'h39);
      rdChk(`ILCR_OFS_PTL, 8'h22);
      chk(8'(vinApp), 8'h05);
      chk(8'(iinApp), 8'h19);
      chk(8'({autoEn, optEn, audioOff}), 8'h06);
      ilcr_host_model_inst.wr(8'h05, 8'hFF);
      rdChk(8'h05, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         d = 8'($random(seed));
         if (i < 4) d[4:0] = corners[i];
         ilcr_host_model_inst.wr(`ILCR_OFS_VIN, d);
         chk(8'({autoEn, bleedEn, audioOff}), 8'(d[7:5]));
         rdChk(`ILCR_OFS_VIN, d);
         chk(8'(vinApp), 8'(vinExp(d[4:0])));
         d = 8'($random(seed));
         d[7] = 1'b0;
         if (i < 4) d[4:0] = corners[3 - i];
         @(negedge clk);
         pinEn = 1'($random(seed));
         pinCode = 5'($random(seed));
         ilcr_host_model_inst.wr(`ILCR_OFS_IIN, d);
         rdChk(`ILCR_OFS_IIN, d);
         chk(8'({detReq, optEn}), 8'(d[6:5]));
         chk(8'(iinApp), 8'(iinExp(d[4:0], pinEn, pinCode)));
         d = 8'($random(seed));
         ilcr_host_model_inst.wr(`ILCR_OFS_PTL, d);
         chk({preCode, termCode}, d);
      end
      $display("test random fields done");
      ilcr_host_model_inst.wr(`ILCR_OFS_IIN, 8'hA0);
      chk(8'(optReq), 8'h01);
      ilcr_host_model_inst.wr(`ILCR_OFS_IIN, 8'h39);
      chk(8'(optReq), 8'h01);
      pulse(optStarted);
      chk(8'(optReq), 8'h00);
      fork
         ilcr_host_model_inst.wr(`ILCR_OFS_IIN, 8'hA0);
         pulse(optStarted);
      join
      chk(8'(optReq), 8'h01);
      pulse(optStarted);
      chk(8'(optReq), 8'h00);
      fork
         ilcr_host_model_inst.wr(`ILCR_OFS_IIN, 8'hA0);
         begin
            @(negedge clk);
            pulse(optStarted);
         end
      join
      chk(8'(optReq), 8'h00);
      ilcr_host_model_inst.wr(`ILCR_OFS_IIN, 8'h80);
      chk(8'({optReq, optEn}), 8'h00);
      $display("test optimizer done");
      ilcr_host_model_inst.wr(`ILCR_OFS_VIN, 8'h93);
      pulse(detDone);
      rdChk(`ILCR_OFS_VIN, 8'h85);
      chk(8'(vinApp), 8'h05);
      ilcr_host_model_inst.wr(`ILCR_OFS_VIN, 8'h13);
      pulse(detDone);
      rdChk(`ILCR_OFS_VIN, 8'h13);
      $display("test plug-in done");
      ilcr_host_model_inst.wr(`ILCR_OFS_VIN, 8'h7F);
      ilcr_host_model_inst.wr(`ILCR_OFS_IIN, 8'h7F);
      ilcr_host_model_inst.wr(`ILCR_OFS_PTL, 8'h5A);
      pulse(wdReset);
      rdChk(`ILCR_OFS_VIN, 8'hBF);
      rdChk(`ILCR_OFS_IIN, 8'h3F);
      rdChk(`ILCR_OFS_PTL, 8'h22);
      $display("test watchdog done");
      closeOut();
   end
endmodule : ilcr_regs_tb_top
